// file: dv/host_model.sv
// host side model: serial receiver, deframer and usb sink
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int BIT_CYCLES = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // framer outputs, and the usb ready returned to the framer
    input  wire logic       txd,
    input  wire logic       usb_valid,
    output logic            usb_ready,
    // bench control and observation
    input  wire logic       slow,
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    output logic            frame_end
);
    logic [15:0] cnt;          // bit timer
    logic [3:0]  nbit;         // 0 idle, 1..8 data, 9 stop
    logic [7:0]  shift;        // bits arrive lsb first
    logic [1:0]  state;        // 0 data, 1 escape, 2 ended
    logic [7:0]  wptr;         // buffer write index
    logic [7:0]  rx_buf [256]; // received record bytes
    logic [2:0]  stall;        // slow sink phase

    // slow sink takes one cycle of eight, so the framer must hold its byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) stall <= 3'h0;
        else if (usb_valid) stall <= stall + 3'h1;
    end
    assign usb_ready = !slow || (stall == 3'h0);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nbit     <= 4'h0;
            cnt      <= 16'h0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (nbit == 4'h0) begin
                // aim at the middle of the first data bit
                if (!txd) begin
                    nbit <= 4'h1;
                    cnt  <= 16'(BIT_CYCLES + BIT_CYCLES / 2 - 2);
                end
            end else if (cnt != 16'h0) cnt <= cnt - 16'h1;
            else if (nbit < 4'h9) begin
                shift <= {txd, shift[7:1]};
                nbit  <= nbit + 4'h1;
                cnt   <= 16'(BIT_CYCLES - 1);
            end else begin
                nbit     <= 4'h0;
                rx_valid <= txd;
                rx_byte  <= shift;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= 2'h0;
            wptr      <= 8'h0;
            frame_end <= 1'b0;
        end else begin
            frame_end <= 1'b0;
            if (rx_valid) begin
                case (state)
                    2'h0: if (rx_byte == 8'h10) state <= 2'h1;
                        else begin
                            rx_buf[wptr] <= rx_byte;
                            wptr         <= wptr + 8'h1;
                        end
                    2'h1: if (rx_byte == 8'h03) begin
                            state     <= 2'h2;
                            frame_end <= 1'b1;
                        end else begin
                            state        <= 2'h0;
                            rx_buf[wptr] <= rx_byte;
                            wptr         <= wptr + 8'h1;
                        end
                    default: if (rx_byte == 8'h10) state <= 2'h1;
                endcase
            end
        end
    end
endmodule : host_model
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the binary record framer
`timescale 1ns/1ps
`default_nettype none
`include "gps_framer_map.svh"
module tb;
    localparam int BITC = 4;   // short bit time keeps the run brief
    localparam int SECC = 200; // short second
    logic        clk, rstn, wr, rd, txd;
    logic        usb_valid, usb_ready, slow;
    logic        rx_valid, frame_end, rd_pend;
    logic [7:0]  addr, usb_data, rx_byte;
    logic [31:0] wdata, rdata;
    logic [31:0] rq[$];        // expected read data
    logic [7:0]  bq[$];        // expected bytes, wire or usb
    logic [7:0]  pl [256];     // payload put in the buffer
    int          num_errors, checks_done, frames_seen, cyc, k, t0;

    gps_binary_record_framer #(.BIT_CYCLES(BITC), .SEC_CYCLES(SECC)) uut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .txd(txd), .usb_valid(usb_valid), .usb_data(usb_data),
        .usb_ready(usb_ready));
    host_model #(.BIT_CYCLES(BITC)) host (
        .clk(clk), .rstn(rstn), .txd(txd), .usb_valid(usb_valid),
        .usb_ready(usb_ready), .slow(slow), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .frame_end(frame_end));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // outputs are settled at the falling edge; oldest note per result
    always @(negedge clk) begin
        if (rd_pend) chk(rdata, rq.pop_front());
        rd_pend = rd;
        if (rx_valid || (usb_valid && usb_ready)) begin
            // a byte nobody expected is always a mismatch
            if (bq.size() == 0) chk(32'hFFFF_FFFF, 32'h0);
            else chk({24'h0, rx_valid ? rx_byte : usb_data}, {24'h0, bq.pop_front()});
        end
        if (frame_end) frames_seen++;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    // inner marker bytes go twice on the serial line
    task automatic put(input logic [7:0] b, input bit esc);
        bq.push_back(b);
        if (esc && b == `GF_MARK) bq.push_back(b);
    endtask : put

    // load a record, note its bytes, launch it, wait for the last byte
    task automatic frame(input logic [7:0] id, wlen, n, input bit usb);
        logic [7:0] sum;
        sum = id + n;
        wr_reg(`GF_REG_ID, {24'h0, id});
        wr_reg(`GF_REG_LEN, {24'h0, wlen});
        wr_reg(`GF_REG_IDX, 32'h0);
        for (int i = 0; i < n; i++) wr_reg(`GF_REG_DATA, {24'h0, pl[i]});
        if (!usb) bq.push_back(`GF_MARK);
        put(id, !usb);
        put(n, !usb);
        for (int i = 0; i < n; i++) begin
            put(pl[i], !usb);
            sum = sum + pl[i];
        end
        // checksum makes the byte sum zero
        if (!usb) put(8'h00 - sum, 1'b1);
        if (!usb) bq.push_back(`GF_MARK);
        if (!usb) bq.push_back(`GF_END);
        wr_reg(`GF_REG_CTRL, {29'h0, 1'b1, usb, 1'b0});
        for (k = 0; k < 8000 && bq.size() != 0; k++) @(posedge clk);
        // a frame that never drains counts against the run
        chk(32'(bq.size()), 32'h0);
        repeat (12 * BITC) @(posedge clk);
    endtask : frame

    initial begin
        rstn = 1'b0;
        {wr, rd, slow, rd_pend} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        {num_errors, checks_done, frames_seen, cyc} = '0;
        void'($urandom(32'h09651681));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // reset values and an unmapped place
        rd_reg(`GF_REG_ID, 32'h72);
        rd_reg(`GF_REG_LEN, 32'h54);
        rd_reg(`GF_REG_CTRL, 32'h0);
        wr_reg(8'h20, 32'hFF);
        rd_reg(8'h20, 32'h0);
        wr_reg(`GF_REG_IDX, 32'hFF);
        wr_reg(`GF_REG_DATA, 32'h5A);
        rd_reg(`GF_REG_IDX, 32'h0);
        for (int i = 0; i < 256; i++) pl[i] = 8'($urandom);
        {pl[1], pl[2]} = 16'h1010;
        // last byte chosen so that the checksum itself is a marker
        pl[5] = 8'hF0 - 8'h33 - 8'h06 - pl[0] - pl[1] - pl[2] - pl[3] - pl[4];
        frame(`GF_POS_ID, 8'h06, 8'h06, 1'b0);
        slow <= 1'b1;
        frame(`GF_MEAS_ID, 8'h08, 8'h08, 1'b1);
        slow <= 1'b0;
        frame(`GF_SAT_ID, 8'h05, `GF_SAT_LEN, 1'b0);
        frame(`GF_MEAS_ID, 8'h00, 8'h00, 1'b0);
        chk(32'(frames_seen), 32'h3);
        // enabled records repeat once per second, here over usb
        wr_reg(`GF_REG_ID, {24'h0, `GF_MEAS_ID});
        wr_reg(`GF_REG_LEN, 32'h0);
        repeat (2) begin
            bq.push_back(`GF_MEAS_ID);
            bq.push_back(8'h00);
        end
        wr_reg(`GF_REG_CTRL, 32'h3);
        for (k = 0; k < 400 && !usb_valid; k++) @(negedge clk);
        t0 = cyc;
        for (k = 0; k < 400 && usb_valid; k++) @(negedge clk);
        for (k = 0; k < 400 && !usb_valid; k++) @(negedge clk);
        chk(32'(cyc - t0), 32'(SECC));
        @(posedge clk);
        wr_reg(`GF_REG_CTRL, 32'h0);
        repeat (10) @(posedge clk);
        rd_reg(`GF_REG_STATUS, 32'h0000_0600);
        chk(32'(bq.size()), 32'h0);
        wrap_up();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire

// file: hdl/gps_binary_record_framer.sv
// binary record framer: serial and usb framing of stored records
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gps_framer_map.svh"

module gps_binary_record_framer #(
    parameter int BIT_CYCLES = `GF_BIT_CYC,
    parameter int SEC_CYCLES = `GF_SEC_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // serial link
    output logic             txd,
    // usb byte stream
    output logic             usb_valid,
    output logic      [7:0]  usb_data,
    input  wire logic        usb_ready
);
    localparam int BW = $clog2(BIT_CYCLES);
    localparam int SW = $clog2(SEC_CYCLES);

    // record buffer, written by software
    logic [7:0] mem [256];
    // sequencer state
    gps_framer_pkg::fsm_type  state, next_state;
    gps_framer_pkg::ctrl_type ctrl, next_ctrl;
    logic [7:0]  rec_id, next_rec_id;   // identifier to send
    logic [7:0]  rec_len, next_rec_len; // payload count
    logic [7:0]  wr_idx, next_wr_idx;   // buffer fill point
    logic [7:0]  rd_idx, next_rd_idx;   // payload position
    logic [7:0]  sum, next_sum;         // running byte sum
    logic        dup, next_dup;         // second copy of 0x10
    logic [7:0]  out_byte, next_out;    // byte on offer
    logic [7:0]  frames, next_frames;   // frames completed
    logic [SW-1:0] sec_cnt, next_sec;   // one second timer
    logic [31:0] next_rdata;
    // uart shifter
    logic [9:0]  ushift, next_ushift;
    logic [3:0]  ubits, next_ubits;
    logic [BW-1:0] ubaud, next_ubaud;
    // handshake terms
    logic accept, stuff, tick, go, eff_end;
    logic [7:0] eff_len;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // satellite record always carries its fixed length
    function automatic logic [7:0] len_of(input logic [7:0] id, input logic [7:0] len);
        len_of = (id == `GF_SAT_ID) ? `GF_SAT_LEN : len;
    endfunction : len_of

    // byte offered in a given state
    function automatic logic [7:0] byte_of(input gps_framer_pkg::fsm_type st,
        input logic [7:0] id, input logic [7:0] len, input logic [7:0] d, input logic [7:0] s);
        case (st)
            gps_framer_pkg::ST_OPEN: byte_of = `GF_MARK;
            gps_framer_pkg::ST_ID:   byte_of = id;
            gps_framer_pkg::ST_CNT:  byte_of = len;
            gps_framer_pkg::ST_DATA: byte_of = d;
            gps_framer_pkg::ST_SUM:  byte_of = 8'(~s + 8'h01);
            gps_framer_pkg::ST_MARK: byte_of = `GF_MARK;
            gps_framer_pkg::ST_FIN:  byte_of = `GF_END;
            default:                 byte_of = 8'h00;
        endcase
    endfunction : byte_of

    // handshakes; usb mode should only change while idle
    assign usb_valid = (state != gps_framer_pkg::ST_IDLE) && ctrl.usb_mode;
    assign accept = (state != gps_framer_pkg::ST_IDLE) &&
                    (ctrl.usb_mode ? usb_ready : (ubits == 4'h0));
    assign stuff = !ctrl.usb_mode && (state inside {gps_framer_pkg::ST_ID,
                   gps_framer_pkg::ST_CNT, gps_framer_pkg::ST_DATA, gps_framer_pkg::ST_SUM});
    assign tick = (sec_cnt == '0);
    assign go = wr && (addr == `GF_REG_CTRL) && wdata[`GF_CTRL_GO];
    assign eff_len = len_of(rec_id, rec_len);
    assign eff_end = ctrl.usb_mode;
    assign usb_data = out_byte;

    // next values of the whole block except the uart shifter and the record buffer
    always_comb begin
        next_state  = state;
        next_ctrl   = ctrl;
        next_rec_id = rec_id;
        next_rec_len = rec_len;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_sum    = sum;
        next_dup    = dup;
        next_frames = frames;
        next_rdata  = 32'h0000_0000;
        next_sec = tick ? SW'(SEC_CYCLES - 1) : sec_cnt - SW'(1);
        // register writes
        if (wr) begin
            case (addr)
                `GF_REG_CTRL: next_ctrl = wdata[1:0];
                `GF_REG_ID:   next_rec_id = wdata[7:0];
                `GF_REG_LEN:  next_rec_len = wdata[7:0];
                `GF_REG_IDX:  next_wr_idx = wdata[7:0];
                `GF_REG_DATA: next_wr_idx = wr_idx + 8'h01;
                default: ;
            endcase
        end
        // register reads, answered next cycle
        if (rd) begin
            case (addr)
                `GF_REG_CTRL:   next_rdata = {30'h0, ctrl};
                `GF_REG_ID:     next_rdata = {24'h0, rec_id};
                `GF_REG_LEN:    next_rdata = {24'h0, rec_len};
                `GF_REG_IDX:    next_rdata = {24'h0, wr_idx};
                `GF_REG_STATUS: next_rdata = {16'h0, frames, 7'h0,
                                  state != gps_framer_pkg::ST_IDLE};
                default:        next_rdata = 32'h0000_0000;
            endcase
        end
        // frame sequencer
        if (state == gps_framer_pkg::ST_IDLE) begin
            if (go || (tick && ctrl.bin_en)) begin
                // usb starts at identifier
                // mode written beside go already governs this frame
                next_state = next_ctrl.usb_mode ? gps_framer_pkg::ST_ID : gps_framer_pkg::ST_OPEN;
                next_sum = 8'h00;
                next_dup = 1'b0;
            end
        end else if (accept) begin
            if (stuff && (out_byte == `GF_MARK) && !dup) begin
                next_dup = 1'b1;
            end else begin
                next_dup = 1'b0;
                case (state)
                    gps_framer_pkg::ST_OPEN: next_state = gps_framer_pkg::ST_ID;
                    gps_framer_pkg::ST_ID: begin
                        next_sum = rec_id;
                        next_state = gps_framer_pkg::ST_CNT;
                    end
                    gps_framer_pkg::ST_CNT: begin
                        next_sum = sum + eff_len;
                        next_rd_idx = 8'h00;
                        if (eff_len != 8'h00)
                            next_state = gps_framer_pkg::ST_DATA;
                        else if (eff_end)
                            next_state = gps_framer_pkg::ST_IDLE;
                        else
                            next_state = gps_framer_pkg::ST_SUM;
                        if (eff_len == 8'h00 && eff_end)
                            next_frames = frames + 8'h01;
                    end
                    gps_framer_pkg::ST_DATA: begin
                        next_sum = sum + out_byte;
                        next_rd_idx = rd_idx + 8'h01;
                        if (rd_idx == eff_len - 8'h01) begin
                            next_state = eff_end ? gps_framer_pkg::ST_IDLE : gps_framer_pkg::ST_SUM;
                            if (eff_end)
                                next_frames = frames + 8'h01;
                        end
                    end
                    gps_framer_pkg::ST_SUM:  next_state = gps_framer_pkg::ST_MARK;
                    gps_framer_pkg::ST_MARK: next_state = gps_framer_pkg::ST_FIN;
                    gps_framer_pkg::ST_FIN: begin
                        next_state = gps_framer_pkg::ST_IDLE;
                        next_frames = frames + 8'h01;
                    end
                    default: next_state = gps_framer_pkg::ST_IDLE;
                endcase
            end
        end
        // channel entries leave in stored order
        next_out = byte_of(next_state, next_rec_id, len_of(next_rec_id, next_rec_len),
                           mem[next_rd_idx], next_sum);
    end

    // uart shifter next values
    always_comb begin
        next_ushift = ushift;
        next_ubits  = ubits;
        next_ubaud  = ubaud;
        if (accept && !ctrl.usb_mode) begin
            next_ushift = {1'b1, out_byte, 1'b0};
            next_ubits  = `GF_UART_BITS;
            next_ubaud  = BW'(BIT_CYCLES - 1);
        end else if (ubits != 4'h0) begin
            if (ubaud == '0) begin
                // bit time over, shift in idle level
                next_ushift = {1'b1, ushift[9:1]};
                next_ubits  = ubits - 4'h1;
                next_ubaud  = BW'(BIT_CYCLES - 1);
            end else begin
                next_ubaud = ubaud - BW'(1);
            end
        end
    end

    // buffer storage has no reset; contents are software's
    always_ff @(posedge clk) begin
        if (wr && addr == `GF_REG_DATA)
            mem[wr_idx] <= wdata[7:0];
    end

    // register all state except the record buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state    <= gps_framer_pkg::ST_IDLE;
            ctrl     <= '0;
            rec_id   <= `GF_ID_RST;
            rec_len  <= `GF_LEN_RST;
            wr_idx   <= 8'h00;
            rd_idx   <= 8'h00;
            sum      <= 8'h00;
            dup      <= 1'b0;
            out_byte <= 8'h00;
            frames   <= 8'h00;
            sec_cnt  <= '0;
            rdata    <= 32'h0000_0000;
            ushift   <= 10'h3FF;
            ubits    <= 4'h0;
            ubaud    <= '0;
        end else begin
            state    <= next_state;
            ctrl     <= next_ctrl;
            rec_id   <= next_rec_id;
            rec_len  <= next_rec_len;
            wr_idx   <= next_wr_idx;
            rd_idx   <= next_rd_idx;
            sum      <= next_sum;
            dup      <= next_dup;
            out_byte <= next_out;
            frames   <= next_frames;
            sec_cnt  <= next_sec;
            rdata    <= next_rdata;
            ushift   <= next_ushift;
            ubits    <= next_ubits;
            ubaud    <= next_ubaud;
        end
    end
    // line level is the shifter's low bit
    assign txd = ushift[0];

    // escape: marker accepted once, then offered again
    sequence first_mark_s;
        accept && stuff && out_byte == `GF_MARK && !dup;
    endsequence
    sequence second_mark_s;
        out_byte == `GF_MARK && dup;
    endsequence
    // opening: marker on offer, then identifier once it is taken
    sequence open_mark_s;
        state == gps_framer_pkg::ST_OPEN && out_byte == `GF_MARK;
    endsequence
    sequence open_taken_s;
        state == gps_framer_pkg::ST_OPEN && accept;
    endsequence

    chk_frame_open: assert property (
        state == gps_framer_pkg::ST_IDLE && next_state == gps_framer_pkg::ST_OPEN
        |=> open_mark_s)
        else $error("frame did not open with marker");
    chk_open_then_id: assert property (
        open_taken_s |=> state == gps_framer_pkg::ST_ID && out_byte == rec_id)
        else $error("marker not followed by identifier");
    chk_sum_zero: assert property (
        state == gps_framer_pkg::ST_SUM |-> 8'(out_byte + sum) == 8'h00)
        else $error("checksum does not cancel byte sum");
    chk_close_pair: assert property (
        state == gps_framer_pkg::ST_MARK && accept |=> out_byte == `GF_END
        && state == gps_framer_pkg::ST_FIN)
        else $error("closing marker not followed by end byte");
    chk_usb_bare: assert property (
        usb_valid |-> state inside {gps_framer_pkg::ST_ID, gps_framer_pkg::ST_CNT,
        gps_framer_pkg::ST_DATA})
        else $error("usb frame carries framing bytes");
    chk_sat_length: assert property (
        state == gps_framer_pkg::ST_CNT && rec_id == `GF_SAT_ID |-> out_byte == `GF_SAT_LEN)
        else $error("satellite record length wrong");
    chk_escape_pair: assert property (
        first_mark_s |=> second_mark_s)
        else $error("inner marker not doubled");
    chk_idx_wrap: assert property (
        wr && addr == `GF_REG_DATA && wr_idx == 8'hFF |=> wr_idx == 8'h00)
        else $error("buffer index did not wrap");
    chk_second_start: assert property (
        tick && ctrl.bin_en && state == gps_framer_pkg::ST_IDLE
        |=> state != gps_framer_pkg::ST_IDLE)
        else $error("enabled frame not started on second tick");
    chk_uart_start: assert property (
        accept && !ctrl.usb_mode |=> !txd [*2])
        else $error("start bit missing");
endmodule : gps_binary_record_framer
`default_nettype wire

// file: include/gps_framer_map.svh
// offsets, byte codes and timing counts for the binary record framer
`ifndef GPS_FRAMER_MAP_SVH
`define GPS_FRAMER_MAP_SVH
// register offsets on the plain register port
`define GF_REG_CTRL     8'h00
`define GF_REG_ID       8'h04
`define GF_REG_LEN      8'h08
`define GF_REG_IDX      8'h0C
`define GF_REG_DATA     8'h10
`define GF_REG_STATUS   8'h14
// control field positions
`define GF_CTRL_BIN     0
`define GF_CTRL_USB     1
`define GF_CTRL_GO      2
// reset values
`define GF_ID_RST       8'h72
`define GF_LEN_RST      8'h54
// frame byte codes
`define GF_MARK         8'h10
`define GF_END          8'h03
// record identifiers and fixed lengths
`define GF_SAT_ID       8'h72
`define GF_SAT_LEN      8'h54
`define GF_POS_ID       8'h33
`define GF_MEAS_ID      8'h34
// timing: 40 MHz clock, 9600 baud, one second
`define GF_CLK_HZ       40000000
`define GF_BAUD         9600
`define GF_BIT_CYC      (`GF_CLK_HZ / `GF_BAUD)
`define GF_SEC_MS       1000
`define GF_SEC_CYC      (`GF_CLK_HZ / 1000 * `GF_SEC_MS)
// uart frame: start, 8 data, stop
`define GF_UART_BITS    4'hA
`endif

// file: include/gps_framer_pkg.sv
// types shared by the binary record framer
package gps_framer_pkg;
    // frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPEN, ST_ID, ST_CNT, ST_DATA, ST_SUM, ST_MARK, ST_FIN
    } fsm_type;
    // software control bits
    typedef struct packed {
        logic usb_mode;
        logic bin_en;
    } ctrl_type;
endpackage : gps_framer_pkg
